// >>> shared/sld_pkg.sv
// Purpose: shared constants for the serial latched driver link
// Assumes: system clock of 200 MHz, period 5 ns
// Notes:   times are kept in ns, cycle counts derived from the clock period
package sld_pkg;
    localparam int SLD_CLK_PERIOD_NS   = 5;
    localparam int SLD_NUM_OUTPUTS     = 32;
    localparam int SLD_SECTION_WIDTH   = 16;
    localparam int SLD_CLOCK_WIDTH_NS  = 150;
    localparam int SLD_SETUP_NS        = 75;
    localparam int SLD_CLK_TO_STB_NS   = 300;
    localparam int SLD_STROBE_WIDTH_NS = 100;
    // least times round up to whole cycles
    localparam int SLD_CLOCK_WIDTH_CYC  = (SLD_CLOCK_WIDTH_NS + SLD_CLK_PERIOD_NS - 1) / SLD_CLK_PERIOD_NS;
    localparam int SLD_SETUP_CYC        = (SLD_SETUP_NS + SLD_CLK_PERIOD_NS - 1) / SLD_CLK_PERIOD_NS;
    localparam int SLD_CLK_TO_STB_CYC   = (SLD_CLK_TO_STB_NS + SLD_CLK_PERIOD_NS - 1) / SLD_CLK_PERIOD_NS;
    localparam int SLD_STROBE_WIDTH_CYC = (SLD_STROBE_WIDTH_NS + SLD_CLK_PERIOD_NS - 1) / SLD_CLK_PERIOD_NS;
    localparam logic [31:0] SLD_RESET_VALUE = 32'h00000000;
endpackage

// >>> shared/sld_if.sv
// Purpose: serial lines between host and driver device
// Assumes: all lines are plain levels driven by logic on sys_clk
// Notes:   shift_clk is sampled by the device, not used as a clock
interface sld_if;
    logic shift_clk;
    logic serial_in;
    logic latch_load;
    logic out_enable;
    logic serial_cascade;
    modport host (output shift_clk, output serial_in, output latch_load, output out_enable, input serial_cascade);
    modport device (input shift_clk, input serial_in, input latch_load, input out_enable, output serial_cascade);
endinterface

// >>> hw/sld_device.sv
// Purpose: 32-output serial input latched driver, device end
// Assumes: serial lines arrive from outside the clock domain and are synchronised
// Notes:   driver outputs are open collector: driver_output high means off
//          each link line passes two flip-flops before use and the chain
//          register adds one more, so the chain moves three sys_clk cycles
//          after the shift clock rises; latches and drivers are clocked
//          samples, not transparent latches, so a user sees them a cycle late
module sld_device
    import sld_pkg::*;
#(
    parameter int SECTION = SLD_SECTION_WIDTH
)
(
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 clk_en,
    // serial link
    sld_if.device                     link,
    // parallel drivers, low = sinking current
    output logic [2*SECTION-1:0]      driver_output,
    // latch contents for observation
    output logic [2*SECTION-1:0]      latch_state
);
    localparam int N = 2 * SECTION;

    // two-flop synchronisers, one bit per link line
    logic [3:0]         sync1;
    logic [3:0]         sync2;
    logic [3:0]         next_sync1;
    logic [3:0]         next_sync2;

    // edge detector on the synchronised shift clock
    logic               clk_prev;
    logic               next_clk_prev;
    logic               rise;

    // named views of the synchronised lines
    logic               data_bit;
    logic               load_open;
    logic               drive_on;

    // the two shift sections, the first one nearest the serial input
    logic [SECTION-1:0] sec_a;
    logic [SECTION-1:0] sec_b;
    logic [SECTION-1:0] next_sec_a;
    logic [SECTION-1:0] next_sec_b;
    logic [N-1:0]       chain;

    // one latch per stage, then the registered drivers
    logic [N-1:0]       latches;
    logic [N-1:0]       next_latches;
    logic [N-1:0]       drv;
    logic [N-1:0]       next_drv;

    // one shift step of a section: a new bit enters stage 0, the top stage leaves
    function automatic logic [SECTION-1:0] shift_step(input logic [SECTION-1:0] stages, input logic enter);
        return {stages[SECTION-2:0], enter};
    endfunction

    // synchroniser next values; only sync2 reads sync1,
    // so no logic ever acts on a bit that may still be settling
    always_comb
    begin
        next_sync1 = {link.out_enable, link.latch_load, link.serial_in, link.shift_clk};
        next_sync2 = sync1;
    end

    // synchroniser registers; clock enable low freezes them like all state
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
        end
        else if (clk_en)
        begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
        end
    end

    // named views of the second stage; every line is seen two cycles late
    assign data_bit  = sync2[1];
    assign load_open = sync2[2];
    assign drive_on  = sync2[3];

    // edge detector; it resets low like the idle shift clock,
    // so leaving reset never looks like a rising edge
    always_comb
    begin
        next_clk_prev = sync2[0];
        rise          = sync2[0] && !clk_prev;
    end

    // edge detector register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_prev <= 1'b0;
        end
        else if (clk_en)
        begin
            clk_prev <= next_clk_prev;
        end
    end

    // shift chain next values; section a feeds section b,
    // so the two sections act as one long chain
    always_comb
    begin
        next_sec_a = sec_a;
        next_sec_b = sec_b;
        if (rise)
        begin
            next_sec_a = shift_step(sec_a, data_bit);
            next_sec_b = shift_step(sec_b, sec_a[SECTION-1]);
        end
    end

    // shift chain registers; a strobe never clears the chain, only reset does
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            {sec_b, sec_a} <= N'(SLD_RESET_VALUE);
        end
        else if (clk_en)
        begin
            sec_a <= next_sec_a;
            sec_b <= next_sec_b;
        end
    end

    // whole chain, stage 0 at bit 0 and the cascade stage on top
    assign chain = {sec_b, sec_a};

    // latch next values: open while the strobe is high, so shifting shows through too;
    // the copy lags the chain by one cycle, which the strobe's width covers
    always_comb
    begin
        next_latches = latches;
        if (load_open)
        begin
            next_latches = chain;
        end
    end

    // latch registers
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            latches <= N'(SLD_RESET_VALUE);
        end
        else if (clk_en)
        begin
            latches <= next_latches;
        end
    end

    // driver next values: off drives every output high and leaves stored data alone
    always_comb
    begin
        next_drv = '1;
        if (drive_on)
        begin
            next_drv = next_latches;
        end
    end

    // driver registers take the latches' next value,
    // so an output never shows a latch state one cycle stale
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            drv <= '1;
        end
        else if (clk_en)
        begin
            drv <= next_drv;
        end
    end

    // outputs straight from flip-flops, so a further device
    // in the chain sees clean levels on the cascade
    assign link.serial_cascade = sec_b[SECTION-1];
    assign driver_output       = drv;
    assign latch_state         = latches;
endmodule

// >>> hw/sld_host.sv
// Purpose: host end that shifts a word out and strobes it into the latches
// Assumes: user holds start for one cycle when ready is high
// Notes:   timing counts come from the package in sys_clk cycles
module sld_host
    import sld_pkg::*;
#(
    parameter int WIDTH = SLD_NUM_OUTPUTS
)
(
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    // user side
    input  wire logic             start,
    input  wire logic [WIDTH-1:0] word,
    input  wire logic             enable_req,
    output logic                  ready,
    // serial link
    sld_if.host                   link
);
    typedef enum logic [2:0] {SLD_IDLE, SLD_SETUP, SLD_HIGH, SLD_LOW, SLD_GAP, SLD_STB} sld_state_t;

    // sequencer state, the outgoing word and its counters
    sld_state_t       state;
    sld_state_t       next_state;
    logic [WIDTH-1:0] shreg;
    logic [WIDTH-1:0] next_shreg;
    logic [7:0]       cnt;
    logic [7:0]       next_cnt;
    logic [7:0]       bits;
    logic [7:0]       next_bits;
    // registered link lines, so the device never sees a glitch
    logic             sclk;
    logic             next_sclk;
    logic             stb;
    logic             next_stb;
    logic             oe;
    logic             next_oe;

    // sequencer: msb first so the first bit ends at the far stage
    always_comb
    begin
        next_state = state;
        next_shreg = shreg;
        next_cnt   = cnt;
        next_bits  = bits;
        next_sclk  = sclk;
        next_stb   = stb;
        next_oe    = enable_req;
        case (state)
            SLD_IDLE:
            begin
                if (start)
                begin
                    next_shreg = word;
                    next_bits  = 8'(WIDTH);
                    next_cnt   = 8'(SLD_SETUP_CYC);
                    next_state = SLD_SETUP;
                end
            end
            SLD_SETUP:
            begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00)
                begin
                    next_sclk  = 1'b1;
                    next_cnt   = 8'(SLD_CLOCK_WIDTH_CYC);
                    next_state = SLD_HIGH;
                end
            end
            SLD_HIGH:
            begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00)
                begin
                    next_sclk  = 1'b0;
                    next_shreg = {shreg[WIDTH-2:0], 1'b0};
                    next_bits  = bits - 8'h01;
                    next_cnt   = 8'(SLD_CLOCK_WIDTH_CYC);
                    next_state = SLD_LOW;
                end
            end
            SLD_LOW:
            begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00)
                begin
                    next_cnt   = (bits == 8'h00) ? 8'(SLD_CLK_TO_STB_CYC) : 8'(SLD_SETUP_CYC);
                    next_state = (bits == 8'h00) ? SLD_GAP : SLD_SETUP;
                end
            end
            SLD_GAP:
            begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00)
                begin
                    next_stb   = 1'b1;
                    next_cnt   = 8'(SLD_STROBE_WIDTH_CYC);
                    next_state = SLD_STB;
                end
            end
            SLD_STB:
            begin
                next_cnt = cnt - 8'h01;
                if (cnt == 8'h00)
                begin
                    next_stb   = 1'b0;
                    next_state = SLD_IDLE;
                end
            end
            default: next_state = SLD_IDLE;
        endcase
    end

    // registers only; clock enable low freezes the whole sequence
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state <= SLD_IDLE;
            shreg <= '0;
            cnt   <= 8'h00;
            bits  <= 8'h00;
            sclk  <= 1'b0;
            stb   <= 1'b0;
            oe    <= 1'b0;
        end
        else if (clk_en)
        begin
            state <= next_state;
            shreg <= next_shreg;
            cnt   <= next_cnt;
            bits  <= next_bits;
            sclk  <= next_sclk;
            stb   <= next_stb;
            oe    <= next_oe;
        end
    end

    // ready is combinational, every link line comes from a flip-flop
    assign ready           = (state == SLD_IDLE);
    assign link.shift_clk  = sclk;
    assign link.serial_in  = shreg[WIDTH-1];
    assign link.latch_load = stb;
    assign link.out_enable = oe; // strobe is pulsed, never tied high
endmodule

// >>> tb/sld_chk.sv
// Purpose: link checks between host end and device end
// Assumes: every link line changes on sys_clk
// Notes:   hi_n, lo_n and in_n saturate, so long idle spans stay legal
module sld_chk
    import sld_pkg::*;
(
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic rst,
    // link lines
    input  wire logic shift_clk,
    input  wire logic serial_in,
    input  wire logic latch_load,
    input  wire logic out_enable,
    input  wire logic serial_cascade
);
    timeunit 1ns;
    timeprecision 1ps;
    // every check samples on sys_clk and sleeps through reset
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0]  hi_n, lo_n, in_n, bits;
    logic [31:0] shadow;
    // shadow of the chain, so cascade is judged on what really went in
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hi_n   <= 8'h00;
            lo_n   <= 8'h00;
            in_n   <= 8'h00;
            bits   <= 8'h00;
            shadow <= 32'h00000000;
        end
        else
        begin
            hi_n   <= !latch_load ? 8'h00 : hi_n + {7'h00, hi_n != 8'hFF};
            lo_n   <= shift_clk ? 8'h00 : lo_n + {7'h00, lo_n != 8'hFF};
            in_n   <= $changed(serial_in) ? 8'h00 : in_n + {7'h00, in_n != 8'hFF};
            bits   <= $rose(shift_clk) ? bits + 8'h01 : (latch_load ? 8'h00 : bits);
            shadow <= $rose(shift_clk) ? {shadow[30:0], serial_in} : shadow;
        end
    end
    // host timing and the chain as seen from the cascade
    a_data_setup: assert property ($rose(shift_clk) |-> in_n >= SLD_SETUP_CYC)
        else $error("serial data changed too close to the shift clock");
    a_clk_to_strobe: assert property ($rose(latch_load) |-> lo_n >= SLD_CLK_TO_STB_CYC)
        else $error("strobe raised too soon after the shift clock");
    a_strobe_width: assert property ($fell(latch_load) |-> hi_n >= SLD_STROBE_WIDTH_CYC)
        else $error("strobe pulse too short");
    a_full_word: assert property ($rose(latch_load) |-> bits == 8'h20)
        else $error("strobe after a partial word");
    a_no_clk_strobe: assert property (latch_load |-> !shift_clk)
        else $error("shift clock high during strobe");
    a_bypass_enable: assert property (latch_load && $rose(shift_clk) |-> !out_enable)
        else $error("drivers enabled while shifting through open latches");
    a_cascade_chain: assert property ($rose(shift_clk) |-> ##5 serial_cascade == shadow[31])
        else $error("cascade is not the last chain stage");
    a_cascade_cause: assert property ($changed(serial_cascade) |-> $past(shift_clk, 2))
        else $error("cascade moved without a shift clock");
endmodule

// >>> tb/test_serial_in_latched_driver.sv
// Purpose: drives the host user side, judges the device outputs
// Assumes: one 200 MHz clock, reset held 12 cycles
// Notes:   whole 32-bit words only, each takes about 2600 cycles
module test_serial_in_latched_driver
    import sld_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        clk_en = 1'b1;
    logic        start = 1'b0;
    logic        enable_req = 1'b0;
    logic [31:0] word = 32'h00000000;
    logic [31:0] held = 32'h00000000;
    logic        ready;
    logic [31:0] driver_output;
    logic [31:0] latch_state;
    int          miscompares = 0;
    int          check_count = 0;
    // both ends joined through one interface, the checker beside it
    sld_if link ();
    sld_host sld_host_inst (.sys_clk, .rst, .clk_en, .start, .word, .enable_req, .ready, .link(link));
    sld_device sld_device_inst (.sys_clk, .rst, .clk_en, .link(link), .driver_output, .latch_state);
    sld_chk sld_chk_inst (.sys_clk, .rst, .shift_clk(link.shift_clk), .serial_in(link.serial_in),
        .latch_load(link.latch_load), .out_enable(link.out_enable), .serial_cascade(link.serial_cascade));
    // free-running clock
    always #2.5 sys_clk = ~sys_clk;
    // one comparison; case inequality so an unknown never passes
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // the verdict, the only place where the run ends
    task automatic conclude();
        if (miscompares == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // bounded wait, a stuck host counts as a mismatch
    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 3000)
        begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 3000)
            miscompares++;
    endtask
    // one word; peeks 500 cycles after start, when the chain is mixed but latches must hold
    task automatic send(input logic [31:0] w);
        wait_ready();
        word = w;
        start = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        repeat (500) @(negedge sys_clk);
        check("host busy", {31'h0, ready}, 32'h00000000);
        check("held latches", latch_state, held);
        wait_ready();
        repeat (4) @(negedge sys_clk);
        held = w;
        check("latches", latch_state, w);
        check("cascade", {31'h0, link.serial_cascade}, {31'h0, w[31]});
    endtask
    task automatic scen_order();
        logic [31:0] tbl [3];
        tbl = '{32'h80000000, 32'h00000001, 32'hA5F00F5A};
        enable_req = 1'b1;
        foreach (tbl[i])
        begin
            send(tbl[i]);
            check("outputs", driver_output, tbl[i]);
        end
    endtask
    // disabling must not touch stored data, and loading still works meanwhile
    task automatic scen_disable();
        enable_req = 1'b0;
        repeat (8) @(negedge sys_clk);
        check("outputs off", driver_output, 32'hFFFFFFFF);
        check("latches kept", latch_state, held);
        send(32'h0000FFFF);
        check("still off", driver_output, 32'hFFFFFFFF);
        enable_req = 1'b1;
        repeat (8) @(negedge sys_clk);
        check("outputs back", driver_output, 32'h0000FFFF);
    endtask
    // clock enable low freezes every host and device flop, so a dropped enable request is not seen
    task automatic scen_freeze();
        clk_en = 1'b0;
        enable_req = 1'b0;
        repeat (8) @(negedge sys_clk);
        check("frozen outputs", driver_output, 32'h0000FFFF);
        check("frozen latches", latch_state, 32'h0000FFFF);
        clk_en = 1'b1;
        repeat (8) @(negedge sys_clk);
        check("thawed off", driver_output, 32'hFFFFFFFF);
        check("thawed latches", latch_state, 32'h0000FFFF);
        enable_req = 1'b1;
        repeat (8) @(negedge sys_clk);
        check("thawed on", driver_output, 32'h0000FFFF);
    endtask
    initial
    begin
        repeat (12) @(negedge sys_clk);
        rst = 1'b0;
        check("reset outputs", driver_output, 32'hFFFFFFFF);
        scen_order();
        scen_disable();
        scen_freeze();
        conclude();
    end
    // about twice the expected run of some 52 us
    initial
    begin
        #100000;
        miscompares++;
        conclude();
    end
endmodule
